// File: inc/pima_pkg.sv
// constants for the parallel multiply-add execute block
package pima_pkg;
    // ---------------------------------------------------------------
    // instruction word layout
    // ---------------------------------------------------------------
    localparam logic [5:0] OPC_PREFIX = 6'h22;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int ROUTE_HI = 25;
    localparam int ROUTE_LO = 24;
    localparam int MDST_BIT = 23;
    localparam int ADST_BIT = 22;
    localparam int REG1_HI = 21;
    localparam int REG1_LO = 19;
    localparam int REG2_HI = 18;
    localparam int REG2_LO = 16;
    // destination register numbers
    localparam logic [2:0] MDST_BASE = 3'h0;
    localparam logic [2:0] ADST_BASE = 3'h2;
    // cycles per instruction by location of the third operand
    localparam int CYC_INTERNAL = 1;
    localparam int CYC_EXTERNAL = 2;
    // ---------------------------------------------------------------
    // register map (byte offsets)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_EXT_REG0 = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    // flags register fields
    localparam int FL_CARRY = 0;
    localparam int FL_OVF = 1;
    localparam int FL_UNDERFLOW = 2;
    localparam int FL_NEG = 3;
    localparam int FL_ZERO = 4;
    localparam int FL_LATCHED_OVF = 5;
    localparam int FL_LATCHED_UF = 6;
    localparam int FLAGS_W = 7;
    // control register fields
    localparam int CT_SATURATE = 0;
    localparam int CT_EXT_OPS = 1;
    localparam int CTRL_W = 2;
    // interrupt event bits
    localparam int EV_DONE = 0;
    localparam int EV_OVF = 1;
    localparam int EV_ILLEGAL = 2;
    localparam int EV_W = 3;
    // reset values
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 7'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : pima_pkg

// File: hw/pima_arith.sv
// integer multiply and add with overflow detection and saturation
`timescale 1ns/1ps
`default_nettype none
module pima_arith #(
    parameter int DW = 32
) (
    input wire logic [DW-1:0] mul_a,
    input wire logic [DW-1:0] mul_b,
    input wire logic [DW-1:0] add_d,
    input wire logic [DW-1:0] add_c,
    input wire logic saturate,
    output logic [DW-1:0] product,
    output logic [DW-1:0] sum,
    output logic mul_ovf,
    output logic add_ovf
);
    // ---------------------------------------------------------------
    // datapath
    // ---------------------------------------------------------------
    localparam int PW = DW + 16;
    logic signed [2*DW-1:0] full_prod;
    logic [PW-1:0] prod48;
    logic [DW-1:0] raw_sum;

    // signed product; upper sixteen bits must echo the result sign
    always_comb begin
        full_prod = $signed({{DW{mul_a[DW-1]}}, mul_a})
            * $signed({{DW{mul_b[DW-1]}}, mul_b});
        prod48 = full_prod[PW-1:0];
        mul_ovf = (prod48[PW-1:DW] != {16{prod48[DW-1]}});
    end

    // sum with signed overflow on matching input signs
    always_comb begin
        raw_sum = add_d + add_c;
        add_ovf = (add_d[DW-1] == add_c[DW-1]) && (raw_sum[DW-1] != add_d[DW-1]);
    end

    // saturate toward the true sign when the mode is on
    always_comb begin
        product = prod48[DW-1:0];
        sum = raw_sum;
        if (saturate && mul_ovf) begin
            product = prod48[PW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        end
        if (saturate && add_ovf) begin
            sum = add_d[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        end
    end
endmodule : pima_arith
`default_nettype wire

// File: hw/pima_exec.sv
// parallel integer multiply and add: decode, execute, register bus
`timescale 1ns/1ps
`default_nettype none
module pima_exec #(
    parameter int DW = 32,
    parameter int NREG = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [DW-1:0] ind3_data,
    input wire logic [DW-1:0] ind4_data,
    input wire logic ind3_is_cpu_reg,
    input wire logic ind4_is_cpu_reg,
    input wire logic op3_external,
    output logic instr_ready,
    output logic exec_done,
    output logic exec_ovf,
    output logic irq
);
    // ---------------------------------------------------------------
    // types and helpers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PIMA_IDLE = 2'b00,
        PIMA_WAIT = 2'b01
    } pima_state_type;

    // operand source per routing value: {a, b, d, c}, 0=reg1..3=ind4
    function automatic logic [7:0] route_sel(input logic [1:0] p);
        case (p)
            2'b00: route_sel = {2'd2, 2'd3, 2'd0, 2'd1};
            2'b01: route_sel = {2'd2, 2'd0, 2'd3, 2'd1};
            2'b10: route_sel = {2'd0, 2'd1, 2'd2, 2'd3};
            2'b11: route_sel = {2'd2, 2'd0, 2'd1, 2'd3};
            default: route_sel = 8'h00;
        endcase
    endfunction : route_sel

    // whether a byte address falls in the register window, word aligned
    function automatic logic is_reg_addr(input logic [7:0] a);
        is_reg_addr = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    endfunction : is_reg_addr

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [DW-1:0] ext_reg_r [NREG];
    logic [pima_pkg::FLAGS_W-1:0] flags_r;
    logic [pima_pkg::CTRL_W-1:0] ctrl_r;
    logic [pima_pkg::EV_W-1:0] irq_stat_r;
    logic [pima_pkg::EV_W-1:0] irq_mask_r;
    pima_state_type state_r;
    logic [31:0] held_word_r;
    logic [DW-1:0] held_ind3_r;
    logic [DW-1:0] held_ind4_r;
    logic held_cpu3_r;
    logic held_cpu4_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic instr_ready_r;
    logic exec_done_r;
    logic exec_ovf_r;
    logic irq_r;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic take;
    logic [31:0] cur_word;
    logic [DW-1:0] cur_ind3;
    logic [DW-1:0] cur_ind4;
    logic cur_cpu3;
    logic cur_cpu4;
    logic legal;
    logic fire;
    logic illegal_ev;
    logic [7:0] sel;
    logic [DW-1:0] src_val [4];
    logic [DW-1:0] op_a;
    logic [DW-1:0] op_b;
    logic [DW-1:0] op_d;
    logic [DW-1:0] op_c;
    logic [2:0] mdst;
    logic [2:0] adst;
    logic [DW-1:0] product;
    logic [DW-1:0] sum;
    logic mul_ovf;
    logic add_ovf;
    logic any_ovf;
    logic dest_ext;

    assign take = ce && instr_valid && instr_ready_r;

    // a two-cycle instruction executes from its held copy
    always_comb begin
        if (state_r == PIMA_WAIT) begin
            cur_word = held_word_r;
            cur_ind3 = held_ind3_r;
            cur_ind4 = held_ind4_r;
            cur_cpu3 = held_cpu3_r;
            cur_cpu4 = held_cpu4_r;
        end else begin
            cur_word = instr_word;
            cur_ind3 = ind3_data;
            cur_ind4 = ind4_data;
            cur_cpu3 = ind3_is_cpu_reg;
            cur_cpu4 = ind4_is_cpu_reg;
        end
    end

    // prefix check; cpu-register operands only in extended mode
    always_comb begin
        legal = (cur_word[pima_pkg::OPC_HI:pima_pkg::OPC_LO] == pima_pkg::OPC_PREFIX);
        if ((cur_cpu3 || cur_cpu4) && !ctrl_r[pima_pkg::CT_EXT_OPS]) begin
            legal = 1'b0;
        end
    end

    // internal operand executes at once, external waits a cycle
    always_comb begin
        fire = 1'b0;
        if (state_r == PIMA_WAIT) begin
            fire = ce && legal;
        end else if (take && !op3_external) begin
            fire = legal;
        end
    end
    assign illegal_ev = ((state_r == PIMA_WAIT) && ce || take && !op3_external) && !legal;

    // gather the four source fields, register values taken live
    always_comb begin
        src_val[0] = ext_reg_r[cur_word[pima_pkg::REG1_HI:pima_pkg::REG1_LO]];
        src_val[1] = ext_reg_r[cur_word[pima_pkg::REG2_HI:pima_pkg::REG2_LO]];
        src_val[2] = cur_cpu3 ? ext_reg_r[cur_word[10:8]] : cur_ind3;
        src_val[3] = cur_cpu4 ? ext_reg_r[cur_word[2:0]] : cur_ind4;
    end

    // routing field chooses which field feeds each unit input
    always_comb begin
        sel = route_sel(cur_word[pima_pkg::ROUTE_HI:pima_pkg::ROUTE_LO]);
        op_a = src_val[sel[7:6]];
        op_b = src_val[sel[5:4]];
        op_d = src_val[sel[3:2]];
        op_c = src_val[sel[1:0]];
    end

    // destination selects
    always_comb begin
        mdst = pima_pkg::MDST_BASE | {2'b00, cur_word[pima_pkg::MDST_BIT]};
        adst = pima_pkg::ADST_BASE | {2'b00, cur_word[pima_pkg::ADST_BIT]};
        dest_ext = (int'(mdst) < NREG) && (int'(adst) < NREG);
    end

    // both operations evaluated together
    pima_arith #(
        .DW(DW)
    ) u_arith (
        .mul_a(op_a),
        .mul_b(op_b),
        .add_d(op_d),
        .add_c(op_c),
        .saturate(ctrl_r[pima_pkg::CT_SATURATE]),
        .product(product),
        .sum(sum),
        .mul_ovf(mul_ovf),
        .add_ovf(add_ovf)
    );
    assign any_ovf = mul_ovf || add_ovf;

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    // two-cycle path parks the word and operands for one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= PIMA_IDLE;
            instr_ready_r <= 1'b0;
            held_word_r <= 32'h0000_0000;
            held_ind3_r <= '0;
            held_ind4_r <= '0;
            held_cpu3_r <= 1'b0;
            held_cpu4_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                PIMA_IDLE: begin
                    instr_ready_r <= 1'b1;
                    if (take && op3_external) begin
                        state_r <= PIMA_WAIT;
                        instr_ready_r <= 1'b0;
                        held_word_r <= instr_word;
                        held_ind3_r <= ind3_data;
                        held_ind4_r <= ind4_data;
                        held_cpu3_r <= ind3_is_cpu_reg;
                        held_cpu4_r <= ind4_is_cpu_reg;
                    end
                end
                PIMA_WAIT: begin
                    state_r <= PIMA_IDLE;
                    instr_ready_r <= 1'b1;
                end
                default: begin
                    state_r <= PIMA_IDLE;
                    instr_ready_r <= 1'b1;
                end
            endcase
        end
    end

    // completion pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exec_done_r <= 1'b0;
            exec_ovf_r <= 1'b0;
        end else if (ce) begin
            exec_done_r <= fire;
            exec_ovf_r <= fire && any_ovf;
        end
    end

    // ---------------------------------------------------------------
    // register file: execute results win over bus writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NREG; i++) begin
                ext_reg_r[i] <= '0;
            end
        end else if (ce) begin
            if (wr_pend_r && is_reg_addr(wr_addr_r) && (int'(wr_addr_r[4:2]) < NREG)) begin
                ext_reg_r[wr_addr_r[4:2]] <= hwdata[DW-1:0];
            end
            if (fire) begin
                ext_reg_r[mdst] <= product;
                ext_reg_r[adst] <= sum;
            end
        end
    end

    // condition flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_r <= pima_pkg::FLAGS_RST;
        end else if (ce) begin
            if (wr_pend_r && wr_addr_r == pima_pkg::OFS_FLAGS) begin
                flags_r <= hwdata[pima_pkg::FLAGS_W-1:0];
            end
            if (fire && dest_ext) begin
                flags_r[pima_pkg::FL_UNDERFLOW] <= 1'b0;
                flags_r[pima_pkg::FL_NEG] <= 1'b0;
                flags_r[pima_pkg::FL_ZERO] <= 1'b0;
                flags_r[pima_pkg::FL_OVF] <= any_ovf;
                if (any_ovf) begin
                    flags_r[pima_pkg::FL_LATCHED_OVF] <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic addr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_mux;
    logic rd_clear;

    assign addr_ok = ce && hsel && hready && htrans[1] && (hsize == pima_pkg::HSIZE_WORD);
    assign rd_addr = haddr[7:0];
    assign rd_clear = addr_ok && !hwrite && (haddr[31:8] == 24'h00_0000)
        && (rd_addr == pima_pkg::OFS_IRQ_STAT);

    // read value; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[31:8] != 24'h00_0000) begin
            rd_mux = 32'h0000_0000;
        end else if (is_reg_addr(rd_addr) && (int'(rd_addr[4:2]) < NREG)) begin
            rd_mux[DW-1:0] = ext_reg_r[rd_addr[4:2]];
        end else if (rd_addr == pima_pkg::OFS_FLAGS) begin
            rd_mux[pima_pkg::FLAGS_W-1:0] = flags_r;
        end else if (rd_addr == pima_pkg::OFS_CTRL) begin
            rd_mux[pima_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (rd_addr == pima_pkg::OFS_IRQ_STAT) begin
            rd_mux[pima_pkg::EV_W-1:0] = irq_stat_r;
        end else if (rd_addr == pima_pkg::OFS_IRQ_MASK) begin
            rd_mux[pima_pkg::EV_W-1:0] = irq_mask_r;
        end
    end

    // address phase capture, read data ready for the data phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
        end else if (ce) begin
            hreadyout_r <= 1'b1;
            wr_pend_r <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
            if (addr_ok) begin
                wr_addr_r <= rd_addr;
            end
            if (addr_ok && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // control and mask registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= pima_pkg::CTRL_RST;
            irq_mask_r <= pima_pkg::IRQ_MASK_RST;
        end else if (ce && wr_pend_r) begin
            if (wr_addr_r == pima_pkg::OFS_CTRL) begin
                ctrl_r <= hwdata[pima_pkg::CTRL_W-1:0];
            end
            if (wr_addr_r == pima_pkg::OFS_IRQ_MASK) begin
                irq_mask_r <= hwdata[pima_pkg::EV_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupts: sticky events, read clears, new event wins
    // ---------------------------------------------------------------
    logic [pima_pkg::EV_W-1:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[pima_pkg::EV_DONE] = fire;
        ev_set[pima_pkg::EV_OVF] = fire && any_ovf;
        ev_set[pima_pkg::EV_ILLEGAL] = illegal_ev;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_stat_r <= (rd_clear ? '0 : irq_stat_r) | ev_set;
            irq_r <= |(((rd_clear ? '0 : irq_stat_r) | ev_set) & irq_mask_r);
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign instr_ready = instr_ready_r;
    assign exec_done = exec_done_r;
    assign exec_ovf = exec_ovf_r;
    assign irq = irq_r;
endmodule : pima_exec
`default_nettype wire

// File: bench/pima_exec_sva.sv
// checker for the execute block ports
`timescale 1ns/1ps
`default_nettype none
module pima_exec_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic ind3_is_cpu_reg,
    input wire logic ind4_is_cpu_reg,
    input wire logic op3_external,
    input wire logic instr_ready,
    input wire logic exec_done,
    input wire logic exec_ovf,
    input wire logic hresp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic take;
    logic good;
    // take and legality of the offered word
    assign take = instr_valid && instr_ready;
    assign good = (instr_word[31:26] == pima_pkg::OPC_PREFIX) && !ind3_is_cpu_reg
        && !ind4_is_cpu_reg;
    sequence s_int;
        take && good && !op3_external;
    endsequence
    sequence s_ext;
        take && good && op3_external;
    endsequence
    sequence s_bad;
        take && (instr_word[31:26] != pima_pkg::OPC_PREFIX);
    endsequence
    AST_INT_ONE: assert property (s_int |=> exec_done)
        else $error("internal instruction not done in one cycle");
    AST_EXT_TWO: assert property (s_ext |=> !exec_done ##1 exec_done)
        else $error("external instruction not done in two cycles");
    AST_EXT_BUSY: assert property (s_ext |=> !instr_ready ##1 instr_ready)
        else $error("ready not low for exactly one cycle");
    AST_BAD_OP: assert property (s_bad |=> !exec_done)
        else $error("unknown opcode completed");
    AST_OVF_DONE: assert property (exec_ovf |-> exec_done)
        else $error("overflow pulse without done");
    AST_DONE_CAUSE: assert property (exec_done |-> $past(take) || $past(take, 2))
        else $error("done without a taken instruction");
    AST_READY_BACK: assert property (!instr_ready && !$past(rst) |=> instr_ready)
        else $error("ready low for more than one cycle");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    COV_EXT: cover property (s_ext);
endmodule : pima_exec_sva
bind pima_exec pima_exec_sva u_sva (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ind3_is_cpu_reg(ind3_is_cpu_reg),
    .ind4_is_cpu_reg(ind4_is_cpu_reg), .op3_external(op3_external),
    .instr_ready(instr_ready), .exec_done(exec_done), .exec_ovf(exec_ovf), .hresp(hresp));
`default_nettype wire

// File: bench/pima_fetch_model.sv
// partner model: instruction fetch and operand memory
`timescale 1ns/1ps
`default_nettype none
module pima_fetch_model (
    input wire logic mclk,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [31:0] instr_word,
    output logic [31:0] ind3_data,
    output logic [31:0] ind4_data,
    output logic ind3_is_cpu_reg,
    output logic ind4_is_cpu_reg,
    output logic op3_external
);
    // idle lines at time zero
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0000_0000;
        ind3_data = 32'h0000_0000;
        ind4_data = 32'h0000_0000;
        ind3_is_cpu_reg = 1'b0;
        ind4_is_cpu_reg = 1'b0;
        op3_external = 1'b0;
    end
    // offer one word, hold until taken, then scramble stale data
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
        input logic x, input logic [1:0] c, output logic tk);
        logic seen;
        int n;
        seen = 1'b0;
        n = 0;
        instr_valid <= 1'b1;
        instr_word <= w;
        ind3_data <= a;
        ind4_data <= b;
        op3_external <= x;
        {ind4_is_cpu_reg, ind3_is_cpu_reg} <= c;
        while (!seen && n < 20) begin
            @(negedge mclk);
            seen = (instr_ready === 1'b1);
            @(posedge mclk);
            n++;
        end
        instr_valid <= 1'b0;
        instr_word <= ~w;
        ind3_data <= ~a;
        ind4_data <= ~b;
        tk = seen;
    endtask : issue
endmodule : pima_fetch_model
`default_nettype wire

// File: bench/pima_exec_bench.sv
// self-checking bench for the parallel multiply-add block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module pima_exec_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] iw, d3, d4;
    logic hrdy, hresp, iv, ir, c3, c4, ext, done, ovf, irq;
    int fail_count = 0;
    int checks_done = 0;
    logic [31:0] ep [4] = '{32'h0000_004d, 32'h0000_0015, 32'h0000_000f, 32'h0000_0015};
    logic [31:0] es [4] = '{32'h0000_0008, 32'h0000_0010, 32'h0000_0012, 32'h0000_0010};
    // clock, 40 ns period
    always #20 mclk = ~mclk;
    pima_exec u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(pima_pkg::HSIZE_WORD), .hready(hrdy),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .instr_valid(iv), .instr_word(iw), .ind3_data(d3), .ind4_data(d4),
        .ind3_is_cpu_reg(c3), .ind4_is_cpu_reg(c4), .op3_external(ext),
        .instr_ready(ir), .exec_done(done), .exec_ovf(ovf), .irq(irq));
    pima_fetch_model u_fm (.mclk(mclk), .instr_ready(ir), .instr_valid(iv),
        .instr_word(iw), .ind3_data(d3), .ind4_data(d4), .ind3_is_cpu_reg(c3),
        .ind4_is_cpu_reg(c4), .op3_external(ext));
    // ----------------------------------------
    // bus and instruction tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic wait_hr(output logic [31:0] rd);
        logic seen;
        int n;
        seen = 1'b0;
        n = 0;
        while (!seen) begin
            @(negedge mclk);
            seen = (hrdy === 1'b1);
            rd = hrdata;
            @(posedge mclk);
            n++;
            if (n > 20) begin
                fail_count++;
                finish_test();
            end
        end
    endtask : wait_hr
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wait_hr(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_hr(rd);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        `CHK($sformatf("reg %h", a), e, x)
    endtask : rc
    task automatic ck_irq(input logic e);
        @(negedge mclk);
        `CHK("irq", e, irq)
        @(posedge mclk);
    endtask : ck_irq
    // f is {external, expect overflow, expect done}
    task automatic run(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
        input logic [1:0] c, input logic [2:0] f);
        logic gd;
        logic go;
        logic tk;
        gd = 1'b0;
        go = 1'b0;
        u_fm.issue(w, a, b, f[2], c, tk);
        `CHK("taken", 1'b1, tk)
        repeat (4) begin
            @(negedge mclk);
            if (done === 1'b1) begin
                gd = 1'b1;
                go = ovf;
            end
            @(posedge mclk);
        end
        `CHK("done", f[0], gd)
        `CHK("ovf", f[1], go)
    endtask : run
    function automatic logic [31:0] mk(input logic [3:0] s, input logic [2:0] r1,
        input logic [2:0] r2, input logic [7:0] i3);
        mk = {pima_pkg::OPC_PREFIX, s, r1, r2, i3, 8'h00};
    endfunction : mk
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rc(8'h24, 32'(pima_pkg::CTRL_RST));
        rc(8'h20, 32'(pima_pkg::FLAGS_RST));
        rc(8'h2c, 32'(pima_pkg::IRQ_MASK_RST));
        rc(8'h30, 32'h0000_0000);
        wr(8'h1c, 32'h0000_0014);
        wr(8'h10, 32'h0000_0064);
        wr(8'h20, 32'h0000_005d);
        run(mk(4'h9, 3'h7, 3'h4, 8'h00), 32'hffff_ffcb, 32'h0000_0035, 2'h0, 3'h1);
        rc(8'h00, 32'h0000_07d0);
        rc(8'h0c, 32'h0000_0000);
        rc(8'h20, 32'h0000_0041);
        wr(8'h10, 32'h0000_0003);
        wr(8'h14, 32'h0000_0005);
        for (int p = 0; p < 4; p++) begin
            run(mk({p[1], p[0], p[0], p[1]}, 3'h4, 3'h5, 8'h00), 32'h0000_0007,
                32'h0000_000b, 2'h0, 3'h1);
            rc({5'h00, p[0], 2'h0}, ep[p]);
            rc({4'h0, 1'b1, p[1], 2'h0}, es[p]);
        end
        // add destination doubles as multiplier source
        wr(8'h08, 32'h0000_0006);
        run(mk(4'h4, 3'h2, 3'h5, 8'h00), 32'h0000_000a, 32'h0000_0009, 2'h0, 3'h1);
        rc(8'h00, 32'h0000_003c);
        rc(8'h08, 32'h0000_000e);
        // overflow, wrap then saturate
        run(mk(4'h0, 3'h4, 3'h5, 8'h00), 32'h0001_0000, 32'h0001_0000, 2'h0, 3'h3);
        rc(8'h00, 32'h0000_0000);
        rc(8'h20, 32'h0000_0063);
        wr(8'h24, 32'h0000_0001);
        run(mk(4'h0, 3'h4, 3'h5, 8'h00), 32'h0001_0000, 32'h0001_0000, 2'h0, 3'h3);
        rc(8'h00, 32'h7fff_ffff);
        run(mk(4'h0, 3'h4, 3'h5, 8'h00), 32'h0000_0002, 32'h0000_0003, 2'h0, 3'h1);
        rc(8'h00, 32'h0000_0006);
        rc(8'h20, 32'h0000_0061);
        // external third operand
        run(mk(4'h0, 3'h4, 3'h5, 8'h00), 32'h0000_0004, 32'h0000_0005, 2'h0, 3'h5);
        rc(8'h00, 32'h0000_0014);
        // refusals, then cpu register operand allowed
        run(mk(4'h8, 3'h4, 3'h5, 8'h04), 32'h0000_00ee, 32'h0000_0064, 2'h1, 3'h0);
        run(mk(4'h0, 3'h4, 3'h5, 8'h00) ^ 32'h8000_0000, 32'h0000_0002, 32'h0000_0003,
            2'h0, 3'h0);
        rc(8'h00, 32'h0000_0014);
        wr(8'h24, 32'h0000_0002);
        run(mk(4'h8, 3'h4, 3'h5, 8'h04), 32'h0000_00ee, 32'h0000_0064, 2'h1, 3'h1);
        rc(8'h00, 32'h0000_000f);
        rc(8'h08, 32'h0000_0067);
        // interrupt: clear, unmask, raise, clear, masked event
        rc(8'h28, 32'h0000_0007);
        ck_irq(1'b0);
        wr(8'h2c, 32'h0000_0001);
        run(mk(4'h0, 3'h4, 3'h5, 8'h00), 32'h0000_0002, 32'h0000_0003, 2'h0, 3'h1);
        ck_irq(1'b1);
        rc(8'h28, 32'h0000_0001);
        ck_irq(1'b0);
        run(mk(4'h0, 3'h4, 3'h5, 8'h00) ^ 32'h8000_0000, 32'h0000_0002, 32'h0000_0003,
            2'h0, 3'h0);
        ck_irq(1'b0);
        rc(8'h28, 32'h0000_0004);
        finish_test();
    end
endmodule : pima_exec_bench
`default_nettype wire
